// [iseb_pkg.sv]
// Package with register map, field positions and reset values of the interrupt source enable bank.
package iseb_pkg;

   // Register byte offsets within the system configuration space.
   localparam logic [15:0] MODE_PRIMARY_OFS = 16'hE200;
   localparam logic [15:0] MODE_SECONDARY_OFS = 16'hE204;
   localparam logic [15:0] ENABLE_PRIMARY_OFS = 16'hE208;
   localparam logic [15:0] ENABLE_SECONDARY_OFS = 16'hE20C;
   localparam logic [15:0] STATUS_PRIMARY_OFS = 16'hE210;
   localparam logic [15:0] STATUS_SECONDARY_OFS = 16'hE214;

   // Register selector codes.
   typedef enum logic [2:0] {
      ISEB_SEL_NONE,
      ISEB_SEL_MODE_PRI,
      ISEB_SEL_MODE_SEC,
      ISEB_SEL_EN_PRI,
      ISEB_SEL_EN_SEC,
      ISEB_SEL_STAT_PRI,
      ISEB_SEL_STAT_SEC
   } iseb_sel_type;

   // Reset values of all control registers.
   localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
   localparam logic [31:0] MODE_RESET = 32'h0000_0000;

   // Field positions of the primary enable register.
   localparam int WAN_TX_IRQ_EN = 30;
   localparam int WAN_RX_IRQ_EN = 29;
   localparam int WAN_TX_NOBUF_IRQ_EN = 28;
   localparam int WAN_RX_NOBUF_IRQ_EN = 27;
   localparam int WAN_TX_STOPPED_IRQ_EN = 26;
   localparam int WAN_RX_STOPPED_IRQ_EN = 25;
   localparam int BUS_ERROR_IRQ_EN = 24;
   localparam int WAN_WAKEUP_IRQ_EN = 19;
   localparam int LAN_WAKEUP_IRQ_EN = 18;
   localparam int LAN_TX_IRQ_EN = 17;
   localparam int LAN_RX_IRQ_EN = 16;
   localparam int LAN_TX_NOBUF_IRQ_EN = 15;
   localparam int LAN_RX_NOBUF_IRQ_EN = 14;
   localparam int LAN_TX_STOPPED_IRQ_EN = 13;
   localparam int LAN_RX_STOPPED_IRQ_EN = 12;
   localparam int USB_DEV_IRQ_EN = 10;
   localparam int USB_HOST_LEGACY_IRQ_EN = 9;
   localparam int USB_HOST_HS_IRQ_EN = 8;
   localparam int SD_HOST_IRQ_EN = 7;
   localparam int CRYPTO_ENGINE_IRQ_EN = 6;
   localparam int DRAM_ERROR_IRQ_EN = 4;

   // Field positions of the secondary enable register.
   localparam int UART_D_LINE_ERR_EN = 25;
   localparam int UART_D_RX_LEVEL_EN = 24;
   localparam int UART_D_TX_EMPTY_EN = 23;
   localparam int UART_C_LINE_ERR_EN = 22;
   localparam int UART_C_RX_LEVEL_EN = 21;
   localparam int UART_C_TX_EMPTY_EN = 20;
   localparam int UART_B_LINE_ERR_EN = 19;
   localparam int UART_B_RX_LEVEL_EN = 18;
   localparam int UART_B_TX_EMPTY_EN = 17;
   localparam int UART_A_MODEM_EN = 16;
   localparam int UART_A_LINE_ERR_EN = 15;
   localparam int UART_A_RX_LEVEL_EN = 14;
   localparam int UART_A_TX_EMPTY_EN = 13;
   localparam int MGMT_SERIAL_IRQ_EN = 12;
   localparam int SPI_IRQ_EN = 11;
   localparam int AUDIO_TX_IRQ_EN = 10;
   localparam int AUDIO_RX_IRQ_EN = 9;
   localparam int TWO_WIRE_IRQ_EN = 8;
   localparam int TIMER_B_IRQ_EN = 7;
   // Lowest secondary field; bits below it are further timer and external enables.
   localparam int SECONDARY_LOW_FIELDS = 7;

   // AHB transfer type bit that marks an active transfer.
   localparam int HTRANS_ACTIVE_BIT = 1;

endpackage

// [iseb_top.sv]
// Interrupt source enable bank with AHB-Lite register access and fast and normal interrupt outputs.
//
// Implementation choice: the AHB-Lite slave port.
module iseb_top (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // AHB-Lite slave port.
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Pending status from the interrupt sources, laid out as the enable registers.
   input wire logic [31:0] src_status_primary_i,
   input wire logic [31:0] src_status_secondary_i,
   // Interrupt lines to the processor core.
   output logic fast_irq_line_o,
   output logic normal_irq_o
);

   // Decodes the low address half into a register selector.
   function automatic iseb_pkg::iseb_sel_type decode_sel(input logic [15:0] ofs);
      iseb_pkg::iseb_sel_type sel;
      sel = iseb_pkg::ISEB_SEL_NONE;
      if (ofs == iseb_pkg::MODE_PRIMARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_MODE_PRI;
      end else if (ofs == iseb_pkg::MODE_SECONDARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_MODE_SEC;
      end else if (ofs == iseb_pkg::ENABLE_PRIMARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_EN_PRI;
      end else if (ofs == iseb_pkg::ENABLE_SECONDARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_EN_SEC;
      end else if (ofs == iseb_pkg::STATUS_PRIMARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_STAT_PRI;
      end else if (ofs == iseb_pkg::STATUS_SECONDARY_OFS) begin
         sel = iseb_pkg::ISEB_SEL_STAT_SEC;
      end
      return sel;
   endfunction

   // Builds a one-hot bit from a field position.
   function automatic logic [31:0] field_bit(input int pos);
      logic [31:0] one;
      one = 32'h0000_0001;
      return one << pos;
   endfunction

   // Writable bits of the primary enable and mode registers; all others are reserved.
   logic [31:0] primary_mask;
   // Writable bits of the secondary enable and mode registers.
   logic [31:0] secondary_mask;

   // Control registers and bus state.
   logic [31:0] enable_primary;
   logic [31:0] enable_secondary;
   logic [31:0] mode_primary;
   logic [31:0] mode_secondary;
   logic wr_pending;
   iseb_pkg::iseb_sel_type wr_sel;

   // Next values and decode.
   logic [31:0] next_enable_primary;
   logic [31:0] next_enable_secondary;
   logic [31:0] next_mode_primary;
   logic [31:0] next_mode_secondary;
   logic [31:0] next_rdata;
   logic addr_valid;
   iseb_pkg::iseb_sel_type addr_sel;
   logic [31:0] pending_primary;
   logic [31:0] pending_secondary;
   logic next_fast;
   logic next_normal;

   // Primary mask from the WAN MAC fields.
   // WAN transmit, receive.
   wire logic [31:0] wan_fields = field_bit(iseb_pkg::WAN_TX_IRQ_EN) | field_bit(iseb_pkg::WAN_RX_IRQ_EN)
      | field_bit(iseb_pkg::WAN_TX_NOBUF_IRQ_EN) | field_bit(iseb_pkg::WAN_RX_NOBUF_IRQ_EN)
      | field_bit(iseb_pkg::WAN_TX_STOPPED_IRQ_EN) | field_bit(iseb_pkg::WAN_RX_STOPPED_IRQ_EN);

   // Primary mask from the bus error and wake-up fields.
   // Bus error response.
   wire logic [31:0] sys_fields = field_bit(iseb_pkg::BUS_ERROR_IRQ_EN)
      | field_bit(iseb_pkg::WAN_WAKEUP_IRQ_EN) | field_bit(iseb_pkg::LAN_WAKEUP_IRQ_EN);

   // Primary mask from the LAN MAC fields.
   // LAN transmit, receive.
   wire logic [31:0] lan_fields = field_bit(iseb_pkg::LAN_TX_IRQ_EN) | field_bit(iseb_pkg::LAN_RX_IRQ_EN)
      | field_bit(iseb_pkg::LAN_TX_NOBUF_IRQ_EN) | field_bit(iseb_pkg::LAN_RX_NOBUF_IRQ_EN)
      | field_bit(iseb_pkg::LAN_TX_STOPPED_IRQ_EN) | field_bit(iseb_pkg::LAN_RX_STOPPED_IRQ_EN);

   // Primary mask from the USB, storage, crypto and memory fields.
   // USB sources.
   wire logic [31:0] host_fields = field_bit(iseb_pkg::USB_DEV_IRQ_EN)
      | field_bit(iseb_pkg::USB_HOST_LEGACY_IRQ_EN) | field_bit(iseb_pkg::USB_HOST_HS_IRQ_EN)
      | field_bit(iseb_pkg::SD_HOST_IRQ_EN) | field_bit(iseb_pkg::CRYPTO_ENGINE_IRQ_EN)
      | field_bit(iseb_pkg::DRAM_ERROR_IRQ_EN);

   // Secondary mask from the UART fields.
   // Fourth UART error, level.
   wire logic [31:0] uart_fields = field_bit(iseb_pkg::UART_D_LINE_ERR_EN)
      | field_bit(iseb_pkg::UART_D_RX_LEVEL_EN) | field_bit(iseb_pkg::UART_D_TX_EMPTY_EN)
      | field_bit(iseb_pkg::UART_C_LINE_ERR_EN) | field_bit(iseb_pkg::UART_C_RX_LEVEL_EN)
      | field_bit(iseb_pkg::UART_C_TX_EMPTY_EN) | field_bit(iseb_pkg::UART_B_LINE_ERR_EN)
      | field_bit(iseb_pkg::UART_B_RX_LEVEL_EN) | field_bit(iseb_pkg::UART_B_TX_EMPTY_EN)
      | field_bit(iseb_pkg::UART_A_MODEM_EN) | field_bit(iseb_pkg::UART_A_LINE_ERR_EN)
      | field_bit(iseb_pkg::UART_A_RX_LEVEL_EN) | field_bit(iseb_pkg::UART_A_TX_EMPTY_EN);

   // Secondary mask from the remaining peripheral fields, timer and external enables below.
   // Management, SPI.
   wire logic [31:0] periph_fields = field_bit(iseb_pkg::MGMT_SERIAL_IRQ_EN) | field_bit(iseb_pkg::SPI_IRQ_EN)
      | field_bit(iseb_pkg::AUDIO_TX_IRQ_EN) | field_bit(iseb_pkg::AUDIO_RX_IRQ_EN)
      | field_bit(iseb_pkg::TWO_WIRE_IRQ_EN) | field_bit(iseb_pkg::TIMER_B_IRQ_EN)
      | (field_bit(iseb_pkg::SECONDARY_LOW_FIELDS) - 32'h0000_0001);

   // Final masks; bits 31 to 26 of the secondary register stay reserved.
   // Reserved secondary bits.
   assign primary_mask = wan_fields | sys_fields | lan_fields | host_fields;
   assign secondary_mask = uart_fields | periph_fields;

   // Address phase decode; a transfer counts only when the bus is ready.
   assign addr_valid = hsel_i & hready_i & htrans_i[iseb_pkg::HTRANS_ACTIVE_BIT];
   assign addr_sel = decode_sel(haddr_i[15:0]);

   // Data phase write; reserved bits are masked so they keep reading zero.
   // Reserved bits ignore writes.
   assign next_enable_primary = (wr_pending && wr_sel == iseb_pkg::ISEB_SEL_EN_PRI) ?
      (hwdata_i & primary_mask) : enable_primary;
   assign next_enable_secondary = (wr_pending && wr_sel == iseb_pkg::ISEB_SEL_EN_SEC) ?
      (hwdata_i & secondary_mask) : enable_secondary;
   assign next_mode_primary = (wr_pending && wr_sel == iseb_pkg::ISEB_SEL_MODE_PRI) ?
      (hwdata_i & primary_mask) : mode_primary;
   assign next_mode_secondary = (wr_pending && wr_sel == iseb_pkg::ISEB_SEL_MODE_SEC) ?
      (hwdata_i & secondary_mask) : mode_secondary;

   // Read data prepared in the address phase from the values that will stand next cycle.
   // Status reads only sample the sources and never clear them.
   // Status kept on read.
   assign next_rdata = (!addr_valid || hwrite_i) ? 32'h0000_0000 :
      (addr_sel == iseb_pkg::ISEB_SEL_EN_PRI) ? next_enable_primary :
      (addr_sel == iseb_pkg::ISEB_SEL_EN_SEC) ? next_enable_secondary :
      (addr_sel == iseb_pkg::ISEB_SEL_MODE_PRI) ? next_mode_primary :
      (addr_sel == iseb_pkg::ISEB_SEL_MODE_SEC) ? next_mode_secondary :
      (addr_sel == iseb_pkg::ISEB_SEL_STAT_PRI) ? src_status_primary_i :
      (addr_sel == iseb_pkg::ISEB_SEL_STAT_SEC) ? src_status_secondary_i : 32'h0000_0000;

   // Sources pass only through their enable bit.
   // Enable gating.
   assign pending_primary = src_status_primary_i & enable_primary;
   assign pending_secondary = src_status_secondary_i & enable_secondary;

   // Each pending source joins the fast line when its mode bit is set, else the normal line.
   // Mode routing.
   assign next_fast = |(pending_primary & mode_primary) | |(pending_secondary & mode_secondary);
   assign next_normal = |(pending_primary & ~mode_primary) | |(pending_secondary & ~mode_secondary);

   // Bus state: remembers a write address phase for its data phase.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_pending <= 1'b0;
         wr_sel <= iseb_pkg::ISEB_SEL_NONE;
      end else begin
         if (hready_i) begin
            wr_pending <= addr_valid & hwrite_i;
            wr_sel <= addr_sel;
         end
      end
   end

   // Control registers; all sources start disabled and routed to the normal line.
   // Reset to zero.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_primary <= iseb_pkg::ENABLE_RESET;
         enable_secondary <= iseb_pkg::ENABLE_RESET;
         mode_primary <= iseb_pkg::MODE_RESET;
         mode_secondary <= iseb_pkg::MODE_RESET;
      end else begin
         enable_primary <= next_enable_primary;
         enable_secondary <= next_enable_secondary;
         mode_primary <= next_mode_primary;
         mode_secondary <= next_mode_secondary;
      end
   end

   // Registered bus answer; the slave never inserts waits and always answers OKAY.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         if (hready_i) begin
            hrdata_o <= next_rdata;
         end
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   // Registered interrupt lines to the core.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fast_irq_line_o <= 1'b0;
         normal_irq_o <= 1'b0;
      end else begin
         fast_irq_line_o <= next_fast;
         normal_irq_o <= next_normal;
      end
   end

endmodule

// [iseb_top_asserts.sv]
// Checker of the enable bank's bus answers, register read-back and interrupt lines.
module iseb_chk (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // AHB-Lite slave port.
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // Sources and interrupt lines.
   input wire logic [31:0] src_status_primary_i,
   input wire logic [31:0] src_status_secondary_i,
   input wire logic fast_irq_line_o,
   input wire logic normal_irq_o
);
   // Writable bits of the primary and secondary layouts.
   localparam logic [31:0] PRI_MASK = 32'h7F0F_F7D0;
   localparam logic [31:0] SEC_MASK = 32'h03FF_FFFF;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // Address phases accepted by the slave, and whether they hit a register.
   wire take = hsel_i && hready_i && htrans_i[1];
   wire mapped = haddr_i[15:0] inside {16'hE200, 16'hE204, 16'hE208, 16'hE20C, 16'hE210, 16'hE214};
   sequence rd_at(logic [15:0] ofs);
      take && !hwrite_i && haddr_i[15:0] == ofs;
   endsequence
   sequence wr_at(logic [15:0] ofs);
      take && hwrite_i && haddr_i[15:0] == ofs;
   endsequence
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("Bus answer was not ready and okay.");
   a_irq_quiet: assert property ($past(src_status_primary_i) == 0 && $past(src_status_secondary_i) == 0
      |-> !fast_irq_line_o && !normal_irq_o)
      else $error("Interrupt raised with no pending source.");
   a_pri_reserved: assert property (rd_at(16'hE208) |=> (hrdata_o & ~PRI_MASK) == 0)
      else $error("Primary reserved enable bits read non-zero.");
   a_sec_reserved: assert property (rd_at(16'hE20C) |=> hrdata_o[31:26] == 6'h00)
      else $error("Secondary reserved enable bits read non-zero.");
   a_mode_reserved: assert property (rd_at(16'hE200) |=> (hrdata_o & ~PRI_MASK) == 0)
      else $error("Primary reserved mode bits read non-zero.");
   a_unmapped_zero: assert property (take && !hwrite_i && !mapped |=> hrdata_o == 0)
      else $error("Unmapped read returned data.");
   a_status_kept: assert property (rd_at(16'hE210) |=> hrdata_o == $past(src_status_primary_i))
      else $error("Status read did not mirror the sources.");
   a_pri_written: assert property (wr_at(16'hE208) ##2 rd_at(16'hE208)
      |=> hrdata_o == ($past(hwdata_i, 2) & PRI_MASK))
      else $error("Primary enable read-back differs from write.");
   a_sec_written: assert property (wr_at(16'hE20C) ##2 rd_at(16'hE20C)
      |=> hrdata_o == ($past(hwdata_i, 2) & SEC_MASK))
      else $error("Secondary enable read-back differs from write.");
endmodule

bind iseb_top iseb_chk chk_u (
   .mclk_i(mclk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .src_status_primary_i(src_status_primary_i),
   .src_status_secondary_i(src_status_secondary_i), .fast_irq_line_o(fast_irq_line_o),
   .normal_irq_o(normal_irq_o));

// [iseb_src_model.sv]
// Behavioural model of the peripheral interrupt sources that feed the enable bank.
module iseb_src_model (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // Events raised and acknowledged by the bench.
   input wire logic [31:0] raise_pri_i,
   input wire logic [31:0] raise_sec_i,
   input wire logic [31:0] ack_pri_i,
   input wire logic [31:0] ack_sec_i,
   // Pending levels towards the bank.
   output logic [31:0] status_pri_o,
   output logic [31:0] status_sec_o
);
   // Pending held.
   // A source keeps its flag until acknowledged, so bank reads can never clear it.
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_pri_o <= 32'h0000_0000;
         status_sec_o <= 32'h0000_0000;
      end else begin
         status_pri_o <= (status_pri_o & ~ack_pri_i) | raise_pri_i;
         status_sec_o <= (status_sec_o & ~ack_sec_i) | raise_sec_i;
      end
   end
endmodule

// [tb.sv]
// Self-checking testbench of the interrupt source enable bank.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus, design outputs, shadows and bookkeeping.
   logic mclk_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, fast_irq_line_o, normal_irq_o;
   logic [1:0] htrans_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, raise_p, raise_s, ack_p, ack_s, st_p, st_s;
   logic [31:0] en_p, en_s, md_p, md_s, rd, d, v;
   int mismatches = 0;
   int tests_run = 0;
   int seed = 92535;
   localparam logic [31:0] MASK_P = 32'h7F0F_F7D0;
   localparam logic [31:0] MASK_S = 32'h03FF_FFFF;

   iseb_top dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .src_status_primary_i(st_p),
      .src_status_secondary_i(st_s), .fast_irq_line_o(fast_irq_line_o), .normal_irq_o(normal_irq_o));
   iseb_src_model src_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .raise_pri_i(raise_p), .raise_sec_i(raise_s),
      .ack_pri_i(ack_p), .ack_sec_i(ack_s), .status_pri_o(st_p), .status_sec_o(st_s));

   // Clock of 25 ns period.
   initial begin
      mclk_i = 1'h0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   // Prints the counts and the verdict, then ends the run.
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Compares a register word.
   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Compares the fast and normal lines.
   task cmp_irq(input logic [1:0] exp);
      tests_run++;
      if ({fast_irq_line_o, normal_irq_o} !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, {fast_irq_line_o, normal_irq_o}, exp);
      end
   endtask

   // Waits a bounded time for hready at a rising edge.
   task wait_ready;
      int i;
      i = 0;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'h1 && i < 64) begin
         @(posedge mclk_i);
         i++;
      end
      if (i == 64) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, hreadyout_o, 1'h1);
         stop_test;
      end
   endtask

   // One single AHB-Lite transfer: address phase, then data phase.
   task xfer(input logic [15:0] a, input logic w, input logic [31:0] wd);
      hsel_i <= 1'h1;
      haddr_i <= {16'h0000, a};
      htrans_i <= 2'h2;
      hwrite_i <= w;
      wait_ready;
      hsel_i <= 1'h0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_ready;
      rd = hrdata_o;
   endtask

   task rd_chk(input logic [15:0] a, input logic [31:0] exp);
      xfer(a, 1'h0, 32'h0000_0000);
      cmp_word(rd, exp);
   endtask

   // Writes modes and enables and keeps the writable part as shadow.
   task set_regs(input logic [31:0] ep, input logic [31:0] es, input logic [31:0] mp, input logic [31:0] ms);
      xfer(16'hE200, 1'h1, mp);
      xfer(16'hE204, 1'h1, ms);
      xfer(16'hE208, 1'h1, ep);
      xfer(16'hE20C, 1'h1, es);
      en_p = ep & MASK_P;
      en_s = es & MASK_S;
      md_p = mp & MASK_P;
      md_s = ms & MASK_S;
   endtask

   // Expected lines: any enabled pending source, split by its mode bit.
   function automatic logic [1:0] exp_irq(input logic [31:0] sp, input logic [31:0] ss);
      return {|((sp & en_p & md_p) | (ss & en_s & md_s)), |((sp & en_p & ~md_p) | (ss & en_s & ~md_s))};
   endfunction

   // Replaces all pending flags, lets the lines settle and checks them.
   task irq_check(input logic [31:0] sp, input logic [31:0] ss);
      raise_p <= sp;
      raise_s <= ss;
      ack_p <= 32'hFFFF_FFFF;
      ack_s <= 32'hFFFF_FFFF;
      @(posedge mclk_i);
      raise_p <= 32'h0000_0000;
      raise_s <= 32'h0000_0000;
      ack_p <= 32'h0000_0000;
      ack_s <= 32'h0000_0000;
      repeat (3) @(posedge mclk_i);
      cmp_irq(exp_irq(sp, ss));
   endtask

   // Main sequence.
   initial begin
      {reset_n_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
      {raise_p, raise_s, ack_p, ack_s} = '0;
      repeat (12) @(posedge mclk_i);
      reset_n_i <= 1'h1;
      @(posedge mclk_i);
      for (int i = 0; i < 4; i++) rd_chk(16'hE200 + 16'(4 * i), 32'h0000_0000);
      $display("Test reset values done");
      for (int i = 0; i < 10; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
         xfer(16'hE208, 1'h1, d);
         rd_chk(16'hE208, d & MASK_P);
         xfer(16'hE20C, 1'h1, ~d);
         rd_chk(16'hE20C, ~d & MASK_S);
         xfer(16'hE200, 1'h1, d);
         rd_chk(16'hE200, d & MASK_P);
         xfer(16'hE204, 1'h1, d);
         rd_chk(16'hE204, d & MASK_S);
         // Shadows follow the last words written, so the next line check knows the gating.
         en_p = d & MASK_P;
         en_s = ~d & MASK_S;
         md_p = d & MASK_P;
         md_s = d & MASK_S;
      end
      $display("Test register access done");
      xfer(16'hE218, 1'h1, 32'hFFFF_FFFF);
      rd_chk(16'hE218, 32'h0000_0000);
      d = $random(seed);
      irq_check(d, ~d);
      xfer(16'hE210, 1'h1, 32'h0000_0000);
      rd_chk(16'hE210, d);
      rd_chk(16'hE210, d);
      rd_chk(16'hE214, ~d);
      $display("Test status reads done");
      for (int b = 0; b < 64; b++) begin
         v = 32'h0000_0001 << (b % 32);
         set_regs(b < 32 ? v : 0, b < 32 ? 0 : v, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
         irq_check(b < 32 ? v : 0, b < 32 ? 0 : v);
         set_regs(b < 32 ? v : 0, b < 32 ? 0 : v, 32'h0000_0000, 32'h0000_0000);
         irq_check(b < 32 ? v : 0, b < 32 ? 0 : v);
         set_regs(b < 32 ? ~v : '1, b < 32 ? '1 : ~v, 32'hFFFF_FFFF, 32'h0000_0000);
         irq_check(b < 32 ? v : 0, b < 32 ? 0 : v);
      end
      $display("Test per-source gating done");
      for (int i = 0; i < 20; i++) begin
         set_regs($random(seed), $random(seed), $random(seed), $random(seed));
         irq_check($random(seed) & $random(seed), $random(seed) & $random(seed));
      end
      $display("Test random gating done");
      // A reset in mid-run must clear every enable and mode and drop both lines.
      reset_n_i <= 1'h0;
      repeat (2) @(posedge mclk_i);
      reset_n_i <= 1'h1;
      @(posedge mclk_i);
      cmp_irq(2'h0);
      for (int i = 0; i < 4; i++) rd_chk(16'hE200 + 16'(4 * i), 32'h0000_0000);
      $display("Test mid-run reset done");
      stop_test;
   end
endmodule
